//--- tb/kbc_far_model.sv
/* Far side of the decoder: pulled-up line pins and a keyboard byte source.
   Assumes the decoder's open-drain enables and its ref_clk. */
`timescale 1ns/1ps
module kbc_far_model
(
  input  wire logic       ref_clk,
  input  wire logic [3:0] oe,
  input  wire logic [3:0] stuck,
  output logic      [3:0] line,
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_byte
);
  // Pull-ups: a line is low only while someone pulls it; stuck forces a fault
  assign line = ~oe & ~stuck;
  ////////////////////////////////////////
  // Byte held until taken; idle data shows the inverse so stale bytes show
  initial rx_valid = 1'h0;
  initial rx_byte = 8'h00;
  always @(posedge ref_clk)
  begin
    if (send)
    begin
      rx_valid <= 1'h1;
      rx_byte <= send_byte;
    end
    else if (rx_valid && rx_ready)
    begin
      rx_valid <= 1'h0;
      rx_byte <= ~rx_byte;
    end
  end
endmodule

//--- tb/tb_top.sv
/* Bench for the host command decoder: AHB-Lite host tasks and command tests.
   Assumes zero-wait answers allowed but not relied on; far side is modelled. */
`timescale 1ns/1ps
module tb_top
  import kbc_pkg::*;
;
  logic        ref_clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        hwrite = 1'h0;
  logic        send = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  in_port = 8'h5A;
  logic [31:0] hrdata;
  logic        hready, hreadyout, hresp, kbd_rx_valid, kbd_rx_ready, mouse_rx_ready;
  logic        kbd_tx_valid, mouse_tx_valid, irq_kbd, irq_mouse;
  logic [7:0]  out_port, kbd_rx_byte, kbd_tx_byte, mouse_tx_byte, r;
  logic [3:0]  oe, ln, lo;
  logic [3:0]  stk = 4'h0;
  logic [7:0]  sb = 8'h00;
  int          errors = 0;
  int          checks_done = 0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  initial forever #50 ref_clk = ~ref_clk;
  kbd_mouse_host_command_decoder DUT (.ref_clk, .arst_n, .hsel(1'h1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .in_port, .out_port,
    .kbd_clock_line_in(ln[0]), .kbd_clock_line_out(lo[0]), .kbd_clock_line_oe(oe[0]),
    .kbd_data_line_in(ln[1]), .kbd_data_line_out(lo[1]), .kbd_data_line_oe(oe[1]),
    .mouse_clock_line_in(ln[2]), .mouse_clock_line_out(lo[2]), .mouse_clock_line_oe(oe[2]),
    .mouse_data_line_in(ln[3]), .mouse_data_line_out(lo[3]), .mouse_data_line_oe(oe[3]),
    .kbd_rx_valid, .kbd_rx_byte, .kbd_rx_ready, .mouse_rx_valid(1'h0), .mouse_rx_byte(8'h00),
    .mouse_rx_ready, .kbd_tx_valid, .kbd_tx_byte, .mouse_tx_valid, .mouse_tx_byte,
    .irq_kbd, .irq_mouse);
  kbc_far_model far (.ref_clk, .oe, .stuck(stk), .line(ln), .send, .send_byte(sb), .rx_ready(kbd_rx_ready),
    .rx_valid(kbd_rx_valid), .rx_byte(kbd_rx_byte));
  ////////////////////////////////////////
  // Verdict and comparison
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Bounded wait for ready sampled high; a hang ends the run
  task automatic wt();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'h1 && n < 50);
    if (hreadyout !== 1'h1)
    begin
      errors++;
      tally_and_finish();
    end
  endtask
  // One single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wt();
    r = hrdata[7:0];
  endtask
  task automatic cw(input logic [7:0] c);
    xfer(1'h1, CMD_OFS, c);
  endtask
  task automatic dw(input logic [7:0] d);
    xfer(1'h1, DATA_OFS, d);
  endtask
  // Poll status until the output buffer is full, bounded
  task automatic wfull();
    int n;
    // Stale read data must not count as a full buffer
    r = 8'h00;
    for (n = 0; n < 60 && r[0] !== 1'h1; n++)
      xfer(1'h0, CMD_OFS, 8'h00);
    if (r[0] !== 1'h1)
    begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic get(input logic [7:0] exp);
    xfer(1'h0, CMD_OFS, 8'h00);
    wfull();
    xfer(1'h0, DATA_OFS, 8'h00);
    chk("data", r, exp);
  endtask
  task automatic ask(input logic [7:0] c, input logic [7:0] exp);
    cw(c);
    get(exp);
  endtask
  // Offer one keyboard byte to the decoder through the far model
  task automatic kick(input logic [7:0] b);
    sb <= b;
    send <= 1'h1;
    tick(1);
    send <= 1'h0;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'h1;
    tick(2);
    chk("out_port", out_port, OUTP_RST);
    xfer(1'h0, CMD_OFS, 8'h00);
    chk("status", r, 8'h10);
    xfer(1'h0, 8'h68, 8'h00);
    chk("unmapped", r, 8'h00);
    chk("hresp", hresp, 8'h00);
    cw(CMD_SELF_TEST);
    wfull();
    chk("status", r, 8'h19);
    get(RSP_PASS);
    xfer(1'h0, CMD_OFS, 8'h00);
    chk("status", r, 8'h18);
    cw(8'h60);
    dw(8'h03);
    xfer(1'h0, CMD_OFS, 8'h00);
    chk("status", r, 8'h10);
    chk("kbd_tx", kbd_tx_byte, 8'h00);
    ask(8'h20, 8'h03);
    cw(8'h61);
    dw(8'hA5);
    ask(8'h21, 8'hA5);
    ask(CMD_PW_CHECK, RSP_PW_NO);
    cw(CMD_PW_LOAD);
    dw(8'h5C);
    dw(8'h00);
    ask(CMD_PW_CHECK, RSP_PW_YES);
    for (int k = 0; k < 2; k++)
    begin
      cw(k ? CMD_KB_DIS : CMD_MS_DIS);
      ask(8'h20, k ? 8'h13 : 8'h23);
      chk("clk_oe", k ? oe[0] : oe[2], 8'h01);
      chk("line_out", {4'h0, lo}, 8'h00);
      cw(k ? CMD_KB_EN : CMD_MS_EN);
      ask(8'h20, 8'h03);
      chk("clk_oe", k ? oe[0] : oe[2], 8'h00);
    end
    ask(CMD_MS_TEST, LT_OK);
    ask(CMD_KB_TEST, LT_OK);
    stk <= 4'h1;
    tick(3);
    ask(CMD_KB_TEST, LT_CLK_LO);
    stk <= 4'h0;
    tick(3);
    ask(CMD_RD_INP, 8'h5A);
    cw(CMD_WR_OUTP);
    dw(8'h3C);
    tick(2);
    chk("out_port", out_port, 8'h3C);
    ask(CMD_RD_OUTP, 8'h3C);
    cw(CMD_WR_KBOB);
    dw(8'h11);
    wfull();
    chk("irq_kbd", irq_kbd, 8'h01);
    get(8'h11);
    cw(CMD_WR_MSOB);
    dw(8'h22);
    wfull();
    chk("status", r, 8'h31);
    chk("irq_mouse", irq_mouse, 8'h01);
    get(8'h22);
    cw(CMD_WR_MOUSE);
    dw(8'h77);
    dw(8'h44);
    tick(2);
    chk("mouse_tx", mouse_tx_byte, 8'h77);
    chk("kbd_tx", kbd_tx_byte, 8'h44);
    ask(CMD_RD_TEST, 8'h03);
    // Bits 3 and 1 selected by the zero bits of F5
    cw(8'hF5);
    tick(5);
    chk("out_port", out_port, 8'h34);
    tick(PULSE_CYC);
    chk("out_port", out_port, 8'h3C);
    ask(8'hC8, RSP_RESEND);
    ask(8'h00, RSP_RESEND);
    // Lock on: a wrong byte is swallowed, the password byte unlocks
    cw(CMD_PW_EN);
    kick(8'h33);
    tick(6);
    xfer(1'h0, CMD_OFS, 8'h00);
    chk("withheld", r[0], 8'h00);
    kick(8'h5C);
    tick(6);
    kick(8'h33);
    get(8'h33);
    tally_and_finish();
  end
endmodule

//--- verilog/kbc_pkg.sv
/*
 * Constants for the host command decoder of the keyboard/mouse controller:
 * bus offsets, command and response codes, configuration byte bit
 * positions, reset values and timing counts.
 * Assumes a single 10 MHz system clock.
 */
package kbc_pkg;

  // Host port byte offsets on the register bus
  localparam logic [7:0] DATA_OFS = 8'h60;
  localparam logic [7:0] CMD_OFS  = 8'h64;

  // Command codes written to the command port
  localparam logic [7:0] CMD_PW_CHECK  = 8'hA4;
  localparam logic [7:0] CMD_PW_LOAD   = 8'hA5;
  localparam logic [7:0] CMD_PW_EN     = 8'hA6;
  localparam logic [7:0] CMD_MS_DIS    = 8'hA7;
  localparam logic [7:0] CMD_MS_EN     = 8'hA8;
  localparam logic [7:0] CMD_MS_TEST   = 8'hA9;
  localparam logic [7:0] CMD_SELF_TEST = 8'hAA;
  localparam logic [7:0] CMD_KB_TEST   = 8'hAB;
  localparam logic [7:0] CMD_KB_DIS    = 8'hAD;
  localparam logic [7:0] CMD_KB_EN     = 8'hAE;
  localparam logic [7:0] CMD_RD_INP    = 8'hC0;
  localparam logic [7:0] CMD_RD_OUTP   = 8'hD0;
  localparam logic [7:0] CMD_WR_OUTP   = 8'hD1;
  localparam logic [7:0] CMD_WR_KBOB   = 8'hD2;
  localparam logic [7:0] CMD_WR_MSOB   = 8'hD3;
  localparam logic [7:0] CMD_WR_MOUSE  = 8'hD4;
  localparam logic [7:0] CMD_RD_TEST   = 8'hE0;
  localparam logic [2:0] GRP_RAM_RD    = 3'h1;
  localparam logic [2:0] GRP_RAM_WR    = 3'h3;
  localparam logic [3:0] GRP_PULSE     = 4'hF;

  // Response codes
  localparam logic [7:0] RSP_PW_YES = 8'hFA;
  localparam logic [7:0] RSP_PW_NO  = 8'hF1;
  localparam logic [7:0] RSP_PASS   = 8'h55;
  localparam logic [7:0] RSP_RESEND = 8'hFE;
  localparam logic [7:0] LT_OK      = 8'h00;
  localparam logic [7:0] LT_CLK_LO  = 8'h01;
  localparam logic [7:0] LT_CLK_HI  = 8'h02;
  localparam logic [7:0] LT_DAT_LO  = 8'h03;
  localparam logic [7:0] LT_DAT_HI  = 8'h04;

  // Configuration byte bits
  localparam int CFG_KB_IRQ = 0;
  localparam int CFG_MS_IRQ = 1;
  localparam int CFG_SYS    = 2;
  localparam int CFG_KB_OFF = 4;
  localparam int CFG_MS_OFF = 5;

  // Reset values
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] OUTP_RST = 8'hFF;

  // Timing
  localparam int CLK_MHZ       = 10;
  localparam int PULSE_NS      = 6000;
  localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int LT_SETTLE_CYC = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_OPER, ST_PWLOAD, ST_LTEST} ctl_state_t;

endpackage

//--- verilog/kbd_mouse_host_command_decoder.sv
/*
 * Host command decoder of the keyboard/mouse controller, as an AHB-Lite
 * slave: data port at 60H, command/status port at 64H.
 * Assumes serial keyboard and mouse links sit outside and exchange whole
 * bytes with this block on the same clock; line pins are open drain.
 */
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module kbd_mouse_host_command_decoder
  import kbc_pkg::*;
#(
  parameter int PW_DEPTH = 8
)
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        kbd_clock_line_in,
  output logic             kbd_clock_line_out,
  output logic             kbd_clock_line_oe,
  input  wire logic        kbd_data_line_in,
  output logic             kbd_data_line_out,
  output logic             kbd_data_line_oe,
  input  wire logic        mouse_clock_line_in,
  output logic             mouse_clock_line_out,
  output logic             mouse_clock_line_oe,
  input  wire logic        mouse_data_line_in,
  output logic             mouse_data_line_out,
  output logic             mouse_data_line_oe,
  input  wire logic [7:0]  in_port,
  output logic      [7:0]  out_port,
  input  wire logic        kbd_rx_valid,
  input  wire logic [7:0]  kbd_rx_byte,
  output logic             kbd_rx_ready,
  input  wire logic        mouse_rx_valid,
  input  wire logic [7:0]  mouse_rx_byte,
  output logic             mouse_rx_ready,
  output logic             kbd_tx_valid,
  output logic      [7:0]  kbd_tx_byte,
  output logic             mouse_tx_valid,
  output logic      [7:0]  mouse_tx_byte,
  output logic             irq_kbd,
  output logic             irq_mouse
);

  localparam int PWI = $clog2(PW_DEPTH);
  localparam int PCW = $clog2(PULSE_CYC + 1);

  // Refuse depths the index logic cannot serve
  if (PW_DEPTH < 2 || PW_DEPTH > 256)
  begin : g_bad_depth
    $error("PW_DEPTH must lie in 2..256");
  end

  typedef struct packed {
    ctl_state_t             st;
    logic [7:0]             cmd;
    logic [31:0][7:0]       ram;
    logic [PW_DEPTH-1:0][7:0] pw;
    logic [PWI-1:0]         pw_idx;
    logic [PWI-1:0]         mt_idx;
    logic                   locked;
    logic [7:0]             ob;
    logic                   obf;
    logic                   ob_ms;
    logic                   cmd_flag;
    logic [7:0]             outp;
    logic [7:0]             pout;
    logic [3:0]             pmask;
    logic [PCW-1:0]         pcnt;
    logic                   lt_ms;
    logic                   lt_drv;
    logic [3:0]             lt_cnt;
    logic [1:0]             lt_rel;
    logic [11:0]            sync1;
    logic [11:0]            sync2;
    logic                   dph_wr;
    logic                   dph_cmd;
    logic                   dph_dat;
    logic [7:0]             rd;
    logic                   hrdy;
    logic                   turn;
    logic                   kb_rdy;
    logic                   ms_rdy;
    logic                   kb_txv;
    logic [7:0]             kb_txb;
    logic                   ms_txv;
    logic [7:0]             ms_txb;
    logic                   irq_k;
    logic                   irq_m;
    logic [3:0]             oe;
  } ctl_t;

  ctl_t       cur_ff;
  ctl_t       nxt_cur;
  logic       bus_act;
  logic       cmd_wr;
  logic       dat_wr;
  logic [7:0] wdat;
  logic       ld;
  logic [7:0] ld_val;
  logic       ld_ms;
  logic [7:0] cfg;
  logic       pw_set;
  logic [7:0] status;
  logic       s_kclk;
  logic       s_kdat;
  logic       s_mclk;
  logic       s_mdat;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and synchronised pins; line tests hold off new commands
  assign bus_act = hsel & htrans[1] & hready;
  assign cmd_wr  = cur_ff.dph_wr & cur_ff.dph_cmd & (cur_ff.st != ST_LTEST);
  assign dat_wr  = cur_ff.dph_wr & cur_ff.dph_dat & (cur_ff.st != ST_LTEST);
  assign wdat    = hwdata[7:0];
  assign cfg     = cur_ff.ram[0];
  assign pw_set  = cur_ff.pw[0] != 8'h00;
  assign s_kclk  = cur_ff.sync2[3];
  assign s_kdat  = cur_ff.sync2[2];
  assign s_mclk  = cur_ff.sync2[1];
  assign s_mdat  = cur_ff.sync2[0];
  assign status  = {2'b00, cur_ff.obf & cur_ff.ob_ms, 1'b1, cur_ff.cmd_flag, cfg[CFG_SYS], 1'b0, cur_ff.obf};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole controller
  always_comb
  begin
    nxt_cur        = cur_ff;
    ld             = 1'b0;
    ld_val         = 8'h00;
    ld_ms          = 1'b0;
    nxt_cur.sync1  = {in_port, kbd_clock_line_in, kbd_data_line_in, mouse_clock_line_in, mouse_data_line_in};
    nxt_cur.sync2  = cur_ff.sync1;
    nxt_cur.kb_txv = 1'b0;
    nxt_cur.ms_txv = 1'b0;
    nxt_cur.turn   = ~cur_ff.turn;
    nxt_cur.hrdy   = 1'b1;

    // Address phase: reads answer at once, so no wait states
    nxt_cur.dph_wr  = bus_act & hwrite;
    nxt_cur.dph_cmd = haddr[7:0] == CMD_OFS;
    nxt_cur.dph_dat = haddr[7:0] == DATA_OFS;
    if (bus_act & ~hwrite)
    begin
      nxt_cur.rd = 8'h00;
      if (haddr[7:0] == DATA_OFS)
      begin
        nxt_cur.rd  = cur_ff.ob;
        nxt_cur.obf = 1'b0;
      end
      else if (haddr[7:0] == CMD_OFS)
      begin
        nxt_cur.rd = status;
      end
    end

    // Command port write; a new command drops any pending operand
    if (cmd_wr)
    begin
      nxt_cur.cmd_flag = 1'b1;
      nxt_cur.st       = ST_IDLE;
      nxt_cur.cmd      = wdat;
      if (wdat[7:5] == GRP_RAM_RD)
      begin
        ld     = 1'b1;
        ld_val = cur_ff.ram[wdat[4:0]];
      end
      else if (wdat[7:5] == GRP_RAM_WR || (wdat >= CMD_WR_OUTP && wdat <= CMD_WR_MOUSE))
      begin
        nxt_cur.st = ST_OPER;
      end
      else if (wdat[7:4] == GRP_PULSE)
      begin
        nxt_cur.pmask = ~wdat[3:0];
        nxt_cur.pcnt  = PCW'(PULSE_CYC);
      end
      else
      begin
        case (wdat)
          CMD_PW_CHECK:
          begin
            ld     = 1'b1;
            ld_val = pw_set ? RSP_PW_YES : RSP_PW_NO;
          end
          CMD_PW_LOAD:
          begin
            nxt_cur.st     = ST_PWLOAD;
            nxt_cur.pw_idx = '0;
          end
          CMD_PW_EN:
          begin
            nxt_cur.locked = pw_set;
            nxt_cur.mt_idx = '0;
          end
          CMD_MS_DIS: nxt_cur.ram[0][CFG_MS_OFF] = 1'b1;
          CMD_MS_EN:  nxt_cur.ram[0][CFG_MS_OFF] = 1'b0;
          CMD_KB_DIS: nxt_cur.ram[0][CFG_KB_OFF] = 1'b1;
          CMD_KB_EN:  nxt_cur.ram[0][CFG_KB_OFF] = 1'b0;
          CMD_MS_TEST, CMD_KB_TEST:
          begin
            nxt_cur.st     = ST_LTEST;
            nxt_cur.lt_ms  = wdat == CMD_MS_TEST;
            nxt_cur.lt_drv = 1'b0;
            nxt_cur.lt_cnt = '0;
          end
          CMD_SELF_TEST:
          begin
            ld     = 1'b1;
            ld_val = RSP_PASS;
          end
          CMD_RD_INP:
          begin
            ld     = 1'b1;
            ld_val = cur_ff.sync2[11:4];
          end
          CMD_RD_OUTP:
          begin
            ld     = 1'b1;
            ld_val = cur_ff.outp;
          end
          CMD_RD_TEST:
          begin
            ld     = 1'b1;
            ld_val = {6'h00, s_kdat, s_kclk};
          end
          default:
          begin
            ld     = 1'b1;
            ld_val = RSP_RESEND;
          end
        endcase
      end
    end

    // Data port write: operand, password byte, or keyboard traffic
    if (dat_wr)
    begin
      nxt_cur.cmd_flag = 1'b0;
      nxt_cur.st       = ST_IDLE;
      case (cur_ff.st)
        ST_OPER:
        begin
          if (cur_ff.cmd[7:5] == GRP_RAM_WR)
            nxt_cur.ram[cur_ff.cmd[4:0]] = wdat;
          else if (cur_ff.cmd == CMD_WR_OUTP)
            nxt_cur.outp = wdat;
          else if (cur_ff.cmd == CMD_WR_MOUSE)
          begin
            nxt_cur.ms_txv = 1'b1;
            nxt_cur.ms_txb = wdat;
          end
          else
          begin
            ld     = 1'b1;
            ld_val = wdat;
            ld_ms  = cur_ff.cmd == CMD_WR_MSOB;
          end
        end
        ST_PWLOAD:
        begin
          // Full table keeps the last byte and ends the load
          nxt_cur.pw[cur_ff.pw_idx] = wdat;
          nxt_cur.pw_idx = cur_ff.pw_idx + PWI'(1);
          if (wdat != 8'h00 && cur_ff.pw_idx != PWI'(PW_DEPTH - 1))
            nxt_cur.st = ST_PWLOAD;
        end
        default:
        begin
          nxt_cur.kb_txv = 1'b1;
          nxt_cur.kb_txb = wdat;
        end
      endcase
    end

    // Line test: sample released, then sample driven low
    if (cur_ff.st == ST_LTEST)
    begin
      nxt_cur.lt_cnt = cur_ff.lt_cnt + 4'h1;
      if (cur_ff.lt_cnt == 4'(LT_SETTLE_CYC))
      begin
        nxt_cur.lt_cnt = '0;
        if (!cur_ff.lt_drv)
        begin
          nxt_cur.lt_drv = 1'b1;
          nxt_cur.lt_rel = cur_ff.lt_ms ? {s_mclk, s_mdat} : {s_kclk, s_kdat};
        end
        else
        begin
          ld         = 1'b1;
          nxt_cur.st = ST_IDLE;
          if (!cur_ff.lt_rel[1])
            ld_val = LT_CLK_LO;
          else if (cur_ff.lt_ms ? s_mclk : s_kclk)
            ld_val = LT_CLK_HI;
          else if (!cur_ff.lt_rel[0])
            ld_val = LT_DAT_LO;
          else if (cur_ff.lt_ms ? s_mdat : s_kdat)
            ld_val = LT_DAT_HI;
          else
            ld_val = LT_OK;
        end
      end
    end

    // Keyboard bytes: swallowed while the password lock is on
    if (kbd_rx_valid && cur_ff.kb_rdy)
    begin
      if (cur_ff.locked)
      begin
        nxt_cur.mt_idx = '0;
        if (kbd_rx_byte == cur_ff.pw[cur_ff.mt_idx])
        begin
          nxt_cur.mt_idx = cur_ff.mt_idx + PWI'(1);
          if (cur_ff.mt_idx == PWI'(PW_DEPTH - 1) || cur_ff.pw[cur_ff.mt_idx + PWI'(1)] == 8'h00)
            nxt_cur.locked = 1'b0;
        end
      end
      else
      begin
        ld     = 1'b1;
        ld_val = kbd_rx_byte;
      end
    end
    if (mouse_rx_valid && cur_ff.ms_rdy)
    begin
      ld     = 1'b1;
      ld_val = mouse_rx_byte;
      ld_ms  = 1'b1;
    end

    // Output pulse timer
    if (cur_ff.pcnt != '0)
      nxt_cur.pcnt = cur_ff.pcnt - PCW'(1);

    // Loading wins over a same-cycle host read
    if (ld)
    begin
      nxt_cur.ob    = ld_val;
      nxt_cur.obf   = 1'b1;
      nxt_cur.ob_ms = ld_ms;
    end

    // Registered outputs; ready alternates so only one source loads
    nxt_cur.pout   = nxt_cur.outp & ~((nxt_cur.pcnt != '0) ? {4'h0, nxt_cur.pmask} : 8'h00);
    nxt_cur.kb_rdy = ~nxt_cur.turn & ~nxt_cur.dph_wr & (nxt_cur.st != ST_LTEST)
                     & ~nxt_cur.ram[0][CFG_KB_OFF] & (nxt_cur.locked | ~nxt_cur.obf);
    nxt_cur.ms_rdy = nxt_cur.turn & ~nxt_cur.dph_wr & (nxt_cur.st != ST_LTEST)
                     & ~nxt_cur.ram[0][CFG_MS_OFF] & ~nxt_cur.obf;
    nxt_cur.irq_k  = nxt_cur.obf & ~nxt_cur.ob_ms & nxt_cur.ram[0][CFG_KB_IRQ];
    nxt_cur.irq_m  = nxt_cur.obf & nxt_cur.ob_ms & nxt_cur.ram[0][CFG_MS_IRQ];
    nxt_cur.oe[3]  = (nxt_cur.st == ST_LTEST && !nxt_cur.lt_ms) ? nxt_cur.lt_drv
                     : nxt_cur.ram[0][CFG_KB_OFF];
    nxt_cur.oe[2]  = nxt_cur.st == ST_LTEST && !nxt_cur.lt_ms && nxt_cur.lt_drv;
    nxt_cur.oe[1]  = (nxt_cur.st == ST_LTEST && nxt_cur.lt_ms) ? nxt_cur.lt_drv
                     : nxt_cur.ram[0][CFG_MS_OFF];
    nxt_cur.oe[0]  = nxt_cur.st == ST_LTEST && nxt_cur.lt_ms && nxt_cur.lt_drv;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_ff        <= '0;
      cur_ff.ram[0] <= CFG_RST;
      cur_ff.outp   <= OUTP_RST;
      cur_ff.pout   <= OUTP_RST;
    end
    else
      cur_ff <= nxt_cur;
  end

  // Port drive; open-drain lines only ever pull low
  assign hrdata               = {24'h000000, cur_ff.rd};
  assign hreadyout            = cur_ff.hrdy;
  assign hresp                = cur_ff.oe[0] & 1'b0;
  assign kbd_clock_line_out   = cur_ff.oe[3] & 1'b0;
  assign kbd_data_line_out    = cur_ff.oe[2] & 1'b0;
  assign mouse_clock_line_out = cur_ff.oe[1] & 1'b0;
  assign mouse_data_line_out  = cur_ff.oe[0] & 1'b0;
  assign kbd_clock_line_oe    = cur_ff.oe[3];
  assign kbd_data_line_oe     = cur_ff.oe[2];
  assign mouse_clock_line_oe  = cur_ff.oe[1];
  assign mouse_data_line_oe   = cur_ff.oe[0];
  assign out_port             = cur_ff.pout;
  assign kbd_rx_ready         = cur_ff.kb_rdy;
  assign mouse_rx_ready       = cur_ff.ms_rdy;
  assign kbd_tx_valid         = cur_ff.kb_txv;
  assign kbd_tx_byte          = cur_ff.kb_txb;
  assign mouse_tx_valid       = cur_ff.ms_txv;
  assign mouse_tx_byte        = cur_ff.ms_txb;
  assign irq_kbd              = cur_ff.irq_k;
  assign irq_mouse            = cur_ff.irq_m;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  rd_cfg_a: assert property ((cmd_wr && wdat == 8'h20) |=> (cur_ff.obf && cur_ff.ob == $past(cfg)))
    else $error("config read mismatch");
  pw_check_a: assert property ((cmd_wr && wdat == CMD_PW_CHECK)
      |=> cur_ff.ob == ($past(pw_set) ? RSP_PW_YES : RSP_PW_NO))
    else $error("password check answer wrong");
  ms_dis_a: assert property ((cmd_wr && wdat == CMD_MS_DIS) |=> cfg[CFG_MS_OFF] ##1 mouse_clock_line_oe)
    else $error("mouse clock not held low");
  self_test_a: assert property ((cmd_wr && wdat == CMD_SELF_TEST) |=> (cur_ff.obf && cur_ff.ob == RSP_PASS))
    else $error("self test answer wrong");
  resend_a: assert property ((cmd_wr && wdat == 8'h00) |=> cur_ff.ob == RSP_RESEND)
    else $error("unknown command not refused");
  pulse_low_a: assert property ((cmd_wr && wdat[7:4] == GRP_PULSE)
      |=> ((out_port[3:0] & ~$past(wdat[3:0])) == 4'h0) ##1 ((out_port[3:0] & cur_ff.pmask) == 4'h0) [*7])
    else $error("output bit not pulsed low");
  obf_clear_a: assert property ((bus_act && !hwrite && haddr[7:0] == DATA_OFS && !ld) |=> !cur_ff.obf)
    else $error("read did not empty buffer");
  kbd_irq_a: assert property ((cur_ff.obf && !cur_ff.ob_ms && cfg[CFG_KB_IRQ]) |-> irq_kbd)
    else $error("keyboard interrupt missing");
  cmd_flag_a: assert property (cmd_wr |=> status[3])
    else $error("command flag not set");
  ms_fwd_a: assert property ((dat_wr && cur_ff.st == ST_OPER && cur_ff.cmd == CMD_WR_MOUSE)
      |=> (mouse_tx_valid && !kbd_tx_valid && mouse_tx_byte == $past(wdat)))
    else $error("mouse byte not forwarded");
  test_in_a: assert property ((cmd_wr && wdat == CMD_RD_TEST) |=> cur_ff.ob[1:0] == $past({s_kdat, s_kclk}))
    else $error("test inputs wrong");

endmodule
